// ---- design/fsf_status_flags.sv ----
// Contract
// - Byte order pin low means big-endian.
// - Big-endian sends high half first.
// - Timing pin low selects asynchronous almost flags.
// - Synchronous almost flags update on own side.
// - Async almost-full falls on write, rises read.
// - Async almost-empty falls on read, rises write.
// - Parity pin high selects interspersed parity.
// - Interspersed: bits 8,17,26,35 are parity.
// - Non-interspersed: bits 32..35 ignored.
// - Parity choice touches only offset loading.
// - Standard full flag low when memory full.
// - Standard full after depth writes.
// - Input ready high when no space left.
// - Input ready counts the output register.
// - Full/input-ready through two register stages.
// - Standard empty flag low when memory empty.
// - Output ready low when first word valid.
// - Output ready rises only on true read.
// - Empty two stages, output ready three.
// - Standard almost-full at depth minus m.
// - Fall-through almost-full at depth+1 minus m.
// - Almost-empty at n, or n+1 fall-through.
// - Mode pin high selects fall-through mode.
// - Writes ignored while memory is full.
`timescale 1ns/1ps
module fsf_status_flags (
    // Clock, reset and clock enable.
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // Reset and option pins, asynchronous to clk_in.
    input wire logic master_reset_n_in,
    input wire logic partial_reset_n_in,
    input wire logic byte_order_select_n_in,
    input wire logic flag_timing_select_in,
    input wire logic parity_placement_select_in,
    input wire logic fall_through_mode_in,
    // Write and read requests from same-clock logic.
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    // Parallel offset programming.
    input wire logic offset_load_in,
    input wire logic offset_sel_full_in,
    input wire logic [35:0] offset_data_in,
    // Bus matching of one long word to two halves.
    input wire logic [35:0] long_word_in,
    input wire logic half_sel_in,
    output logic [17:0] half_word_out,
    // Flags.
    output logic full_flag_n_out,
    output logic empty_flag_n_out,
    output logic almost_full_flag_n_out,
    output logic almost_empty_flag_n_out,
    // Captured options and offsets.
    output fsf_pkg::fsf_cfg_s cfg_out,
    output logic [15:0] empty_offset_out,
    output logic [15:0] full_offset_out
);

    logic [5:0] sync_a_q;
    logic [5:0] sync_b_q;
    logic [5:0] sync_a_d;
    logic [5:0] sync_b_d;
    logic mreset_act;
    logic preset_act;
    logic fall;
    fsf_pkg::fsf_cfg_s cfg_q;
    fsf_pkg::fsf_cfg_s cfg_d;
    logic [15:0] n_q;
    logic [15:0] n_d;
    logic [15:0] m_q;
    logic [15:0] m_d;
    logic [15:0] unpacked;
    logic [16:0] cnt_q;
    logic [16:0] cnt_d;
    logic out_valid_q;
    logic out_valid_d;
    logic full_int;
    logic write_acc;
    logic read_acc;
    logic load_out;
    logic [17:0] words_d;
    logic [17:0] empty_thr;
    logic [17:0] full_thr;
    logic aempty_cond;
    logic afull_cond;
    logic full_s1_q;
    logic full_s1_d;
    logic full_o_q;
    logic full_o_d;
    logic empty_s1_q;
    logic empty_s1_d;
    logic empty_o_q;
    logic empty_o_d;
    logic afull_q;
    logic afull_d;
    logic aempty_q;
    logic aempty_d;
    logic [17:0] half_q;
    logic [17:0] half_d;

    // Two-stage synchroniser for every pin; only stage two is ever read.
    always_comb begin
        sync_a_d = {fall_through_mode_in, parity_placement_select_in,
                    flag_timing_select_in, byte_order_select_n_in,
                    partial_reset_n_in, master_reset_n_in};
        sync_b_d = sync_a_q;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync_a_q <= fsf_pkg::FSF_PIN_RST;
            sync_b_q <= fsf_pkg::FSF_PIN_RST;
        end else if (ce_in) begin
            sync_a_q <= sync_a_d;
            sync_b_q <= sync_b_d;
        end
    end

    assign mreset_act = !sync_b_q[fsf_pkg::FSF_PIN_MRESET];
    assign preset_act = !sync_b_q[fsf_pkg::FSF_PIN_PRESET];
    assign fall = (cfg_q.mode == fsf_pkg::FSF_FALL_THROUGH_MODE);

    fsf_offset_unpack fsf_offset_unpack_inst (
        .data_in(offset_data_in),
        .interspersed_in(cfg_q.interspersed),
        .offset_out(unpacked)
    );

    // Options follow the pins while master reset is held, so the last
    // sample before release is what stays until the next master reset.
    always_comb begin
        cfg_d = cfg_q;
        n_d = n_q;
        m_d = m_q;
        if (mreset_act) begin
            cfg_d.little_endian = sync_b_q[fsf_pkg::FSF_PIN_ORDER];
            cfg_d.sync_flags = sync_b_q[fsf_pkg::FSF_PIN_TIMING];
            cfg_d.interspersed = sync_b_q[fsf_pkg::FSF_PIN_PARITY];
            cfg_d.mode = sync_b_q[fsf_pkg::FSF_PIN_MODE] ?
                fsf_pkg::FSF_FALL_THROUGH_MODE :
                fsf_pkg::FSF_STANDARD_FLAG_MODE;
            n_d = fsf_pkg::FSF_EMPTY_OFF_RST;
            m_d = fsf_pkg::FSF_FULL_OFF_RST;
        end else if (offset_load_in) begin
            if (offset_sel_full_in) begin
                m_d = unpacked;
            end else begin
                n_d = unpacked;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cfg_q <= fsf_pkg::FSF_CFG_RST;
            n_q <= fsf_pkg::FSF_EMPTY_OFF_RST;
            m_q <= fsf_pkg::FSF_FULL_OFF_RST;
        end else if (ce_in) begin
            cfg_q <= cfg_d;
            n_q <= n_d;
            m_q <= m_d;
        end
    end

    // Occupancy. In fall-through the output register is one more slot,
    // so capacity is depth plus one.
    always_comb begin
        full_int = (cnt_q == fsf_pkg::FSF_DEPTH[16:0]) &&
                   (!fall || out_valid_q);
        write_acc = wr_en_in && !full_int;
        load_out = fall && (cnt_q != fsf_pkg::FSF_CNT_RST) &&
                   (!out_valid_q || rd_en_in);
        read_acc = fall ? (rd_en_in && out_valid_q) :
                   (rd_en_in && (cnt_q != fsf_pkg::FSF_CNT_RST));
        out_valid_d = out_valid_q;
        if (load_out) begin
            out_valid_d = 1'b1;
        end else if (read_acc) begin
            out_valid_d = 1'b0;
        end
        cnt_d = cnt_q;
        if (write_acc && !(fall ? load_out : read_acc)) begin
            cnt_d = cnt_q + 17'h00001;
        end else if (!write_acc && (fall ? load_out : read_acc)) begin
            cnt_d = cnt_q - 17'h00001;
        end
        if (mreset_act || preset_act) begin
            cnt_d = fsf_pkg::FSF_CNT_RST;
            out_valid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= fsf_pkg::FSF_CNT_RST;
            out_valid_q <= 1'b0;
        end else if (ce_in) begin
            cnt_q <= cnt_d;
            out_valid_q <= out_valid_d;
        end
    end

    // Almost flags come from the next occupancy, so a flag never lags a
    // pipeline stage more than its documented register count.
    always_comb begin
        words_d = {1'b0, cnt_d} + {17'h00000, out_valid_d};
        empty_thr = {2'h0, n_q} + {17'h00000, fall};
        full_thr = fsf_pkg::FSF_DEPTH + {17'h00000, fall}
                   - {2'h0, m_q};
        aempty_cond = (words_d <= empty_thr);
        afull_cond = (words_d >= full_thr);
        full_s1_d = fall ? full_int : !full_int;
        full_o_d = full_s1_q;
        empty_s1_d = fall ? !out_valid_q :
                     (cnt_q != fsf_pkg::FSF_CNT_RST);
        empty_o_d = empty_s1_q;
        afull_d = afull_q;
        aempty_d = aempty_q;
        if (cfg_q.sync_flags) begin
            afull_d = !afull_cond;
            aempty_d = !aempty_cond;
        end else begin
            if (write_acc && afull_cond) begin
                afull_d = 1'b0;
            end else if (read_acc && !afull_cond) begin
                afull_d = 1'b1;
            end
            if (read_acc && aempty_cond) begin
                aempty_d = 1'b0;
            end else if (write_acc && !aempty_cond) begin
                aempty_d = 1'b1;
            end
        end
        if (mreset_act || preset_act) begin
            afull_d = 1'b1;
            aempty_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            full_s1_q <= 1'b1;
            full_o_q <= 1'b1;
            empty_s1_q <= 1'b0;
            empty_o_q <= 1'b0;
            afull_q <= 1'b1;
            aempty_q <= 1'b0;
        end else if (ce_in) begin
            full_s1_q <= full_s1_d;
            full_o_q <= full_o_d;
            empty_s1_q <= empty_s1_d;
            empty_o_q <= empty_o_d;
            afull_q <= afull_d;
            aempty_q <= aempty_d;
        end
    end

    // Bus matching: the half picked first depends on the captured order.
    always_comb begin
        half_d = (cfg_q.little_endian ^ half_sel_in) ?
            long_word_in[fsf_pkg::FSF_LO_LSB +: 18] :
            long_word_in[fsf_pkg::FSF_HI_LSB +: 18];
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            half_q <= 18'h00000;
        end else if (ce_in) begin
            half_q <= half_d;
        end
    end

    assign full_flag_n_out = full_o_q;
    assign empty_flag_n_out = empty_o_q;
    assign almost_full_flag_n_out = afull_q;
    assign almost_empty_flag_n_out = aempty_q;
    assign cfg_out = cfg_q;
    assign empty_offset_out = n_q;
    assign full_offset_out = m_q;
    assign half_word_out = half_q;

    // Checks on the flags, the count, the captured options and the bus matching.
    default clocking fsf_cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    AST_FULL_IGNORES_WRITE: assert property (
        (ce_in && full_int && !fall && !rd_en_in && !mreset_act &&
         !preset_act)
        |=> (cnt_q == $past(cnt_q)))
        else $error("Write accepted while full.");

    AST_CNT_BOUNDED: assert property (
        cnt_q <= fsf_pkg::FSF_DEPTH[16:0])
        else $error("Count exceeds depth.");

    AST_FALL_FULL_HOLDS_OUT: assert property (
        (ce_in && fall && full_int) ##1 ce_in |=> full_flag_n_out)
        else $error("Input ready low with memory and output full.");

    AST_FULL_TWO_STAGE: assert property (
        (ce_in && $past(ce_in) && $past(ce_in, 2) && !fall &&
         !mreset_act && $past(!mreset_act, 3))
        |-> (full_flag_n_out == !$past(full_int, 2)))
        else $error("Full flag not two stages behind.");

    AST_EMPTY_TWO_STAGE: assert property (
        (ce_in && $past(ce_in) && $past(ce_in, 2) && !fall &&
         !mreset_act && $past(!mreset_act, 3))
        |-> (empty_flag_n_out == ($past(cnt_q, 2) != 17'h00000)))
        else $error("Empty flag not two stages behind.");

    AST_READY_THREE_STAGE: assert property (
        (ce_in && $past(ce_in) && $past(ce_in, 2) && fall &&
         !mreset_act && $past(!mreset_act, 3))
        |-> (empty_flag_n_out == !$past(out_valid_q, 2)))
        else $error("Output ready not three stages behind.");

    AST_ASYNC_AFULL_FALL: assert property (
        (!cfg_q.sync_flags && $fell(almost_full_flag_n_out))
        |-> $past(write_acc && ce_in))
        else $error("Almost-full fell without a write.");

    AST_ASYNC_AEMPTY_RISE: assert property (
        (!cfg_q.sync_flags && $rose(almost_empty_flag_n_out) &&
         !mreset_act)
        |-> $past(write_acc && ce_in))
        else $error("Almost-empty rose without a write.");

    AST_CFG_HELD: assert property (
        (!mreset_act && $past(!mreset_act)) |-> $stable(cfg_q))
        else $error("Options changed outside master reset.");

    AST_BIG_ENDIAN_FIRST: assert property (
        (ce_in && !cfg_q.little_endian && !half_sel_in && !mreset_act)
        |=> (half_word_out == $past(long_word_in[35:18])))
        else $error("Big-endian did not send high half first.");

    COV_FULL: cover property (!full_flag_n_out && !fall);
    COV_READY: cover property (fall && $fell(empty_flag_n_out));
    COV_ASYNC_AFULL: cover property (!cfg_q.sync_flags && $fell(afull_q));

endmodule : fsf_status_flags

// ---- design/fsf_pkg.sv ----
package fsf_pkg;

    // Memory geometry of the smaller variant; the larger one doubles depth.
    localparam int unsigned FSF_CNT_W = 17;
    localparam int unsigned FSF_WORD_W = 18;
    localparam int unsigned FSF_OFF_W = 16;
    localparam int unsigned FSF_DATA_W = 36;
    localparam int unsigned FSF_HALF_W = 18;
    localparam logic [17:0] FSF_DEPTH = 18'h10000;

    // Field positions of the two halves of a long word.
    localparam int unsigned FSF_HI_LSB = 18;
    localparam int unsigned FSF_LO_LSB = 0;

    // Synchroniser bit positions for the pin inputs.
    localparam int unsigned FSF_PIN_W = 6;
    localparam int unsigned FSF_PIN_MRESET = 0;
    localparam int unsigned FSF_PIN_PRESET = 1;
    localparam int unsigned FSF_PIN_ORDER = 2;
    localparam int unsigned FSF_PIN_TIMING = 3;
    localparam int unsigned FSF_PIN_PARITY = 4;
    localparam int unsigned FSF_PIN_MODE = 5;
    localparam logic [5:0] FSF_PIN_RST = 6'h03;

    // Values after reset.
    localparam logic [15:0] FSF_EMPTY_OFF_RST = 16'h007F;
    localparam logic [15:0] FSF_FULL_OFF_RST = 16'h007F;
    localparam logic [16:0] FSF_CNT_RST = 17'h00000;

    // Flag timing discipline on the output pins.
    typedef enum logic {
        FSF_STANDARD_FLAG_MODE,
        FSF_FALL_THROUGH_MODE
    } fsf_mode_e;

    // Options captured while master reset is held.
    typedef struct packed {
        logic little_endian;
        logic sync_flags;
        logic interspersed;
        fsf_mode_e mode;
    } fsf_cfg_s;

    localparam fsf_cfg_s FSF_CFG_RST = '{
        little_endian: 1'b0,
        sync_flags: 1'b0,
        interspersed: 1'b0,
        mode: FSF_STANDARD_FLAG_MODE
    };

endpackage : fsf_pkg

// ---- design/fsf_offset_unpack.sv ----
`timescale 1ns/1ps
// Extracts a flag offset from a parallel data word, skipping parity lanes.
module fsf_offset_unpack (
    // Parallel word and placement choice.
    input wire logic [35:0] data_in,
    input wire logic interspersed_in,
    // Extracted offset.
    output logic [15:0] offset_out
);

    // Interspersed parity drops bits 8, 17, 26 and 35; otherwise 32..35 go.
    function automatic logic [31:0] fsf_squeeze(input logic [35:0] d,
                                                input logic inter);
        logic [31:0] r;
        r = d[31:0];
        if (inter) begin
            r = {d[34:27], d[25:18], d[16:9], d[7:0]};
        end
        return r;
    endfunction : fsf_squeeze

    logic [31:0] squeezed;

    // Only the offset path sees this; stored data never passes here.
    always_comb begin
        squeezed = fsf_squeeze(data_in, interspersed_in);
        offset_out = squeezed[15:0];
    end

endmodule : fsf_offset_unpack

// ---- verification/fsf_peer.sv ----
`timescale 1ns/1ps
// Writer and reader logic on the far side; pins move on falling edges.
module fsf_peer (
    // Clock.
    input wire logic clk_in,
    // Reset and option pins.
    output logic master_reset_n_out,
    output logic partial_reset_n_out,
    output logic byte_order_select_n_out,
    output logic flag_timing_select_out,
    output logic parity_placement_select_out,
    output logic fall_through_mode_out,
    // Requests.
    output logic wr_en_out,
    output logic rd_en_out
);
    // Pins idle inactive, so no reset is implied at time zero.
    initial begin
        master_reset_n_out = 1'b1;
        partial_reset_n_out = 1'b1;
        byte_order_select_n_out = 1'b0;
        flag_timing_select_out = 1'b0;
        parity_placement_select_out = 1'b0;
        fall_through_mode_out = 1'b0;
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
    end

    // Options stay put across release, then flip to show they are ignored.
    task automatic master_reset_pulse(input fsf_pkg::fsf_cfg_s c);
        @(negedge clk_in);
        byte_order_select_n_out = c.little_endian;
        flag_timing_select_out = c.sync_flags;
        parity_placement_select_out = c.interspersed;
        fall_through_mode_out = c.mode;
        master_reset_n_out = 1'b0;
        repeat (6) @(negedge clk_in);
        master_reset_n_out = 1'b1;
        repeat (3) @(negedge clk_in);
        byte_order_select_n_out = ~c.little_endian;
        flag_timing_select_out = ~c.sync_flags;
        parity_placement_select_out = ~c.interspersed;
        fall_through_mode_out = ~c.mode;
        repeat (4) @(negedge clk_in);
    endtask : master_reset_pulse

    // Partial reset held long enough to pass the pin synchroniser.
    task automatic partial_reset_pulse();
        @(negedge clk_in);
        partial_reset_n_out = 1'b0;
        repeat (6) @(negedge clk_in);
        partial_reset_n_out = 1'b1;
        repeat (6) @(negedge clk_in);
    endtask : partial_reset_pulse

    // One request per cycle for n cycles, then idle.
    task automatic burst(input logic rd, input int n);
        repeat (n) begin
            @(negedge clk_in);
            if (rd) begin
                rd_en_out = 1'b1;
            end else begin
                wr_en_out = 1'b1;
            end
        end
        @(negedge clk_in);
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
    endtask : burst
endmodule : fsf_peer

// ---- verification/fsf_status_flags_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the status flag block.
module fsf_status_flags_tb;
    // Bench-driven stimulus; only the clock enable is tied.
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic offset_load_in = 1'b0;
    logic offset_sel_full_in = 1'b0;
    logic [35:0] offset_data_in = 36'h0;
    logic [35:0] long_word_in = 36'h9ABCD1234;
    logic half_sel_in = 1'b0;
    logic master_reset_n, partial_reset_n, byte_order_select_n;
    logic flag_timing_select, parity_placement_select, fall_through_mode;
    logic wr_en, rd_en, full_n, empty_n, af_n, ae_n;
    logic [17:0] half_word;
    logic [15:0] n_off, m_off;
    fsf_pkg::fsf_cfg_s cfg;
    int fails = 0;
    int num_checks = 0;

    // Free-running 100 MHz clock.
    always #5 clk_in = ~clk_in;

    fsf_peer fsf_peer_inst (.clk_in(clk_in),
        .master_reset_n_out(master_reset_n),
        .partial_reset_n_out(partial_reset_n),
        .byte_order_select_n_out(byte_order_select_n),
        .flag_timing_select_out(flag_timing_select),
        .parity_placement_select_out(parity_placement_select),
        .fall_through_mode_out(fall_through_mode),
        .wr_en_out(wr_en), .rd_en_out(rd_en));

    fsf_status_flags fsf_status_flags_inst (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .ce_in(1'b1),
        .master_reset_n_in(master_reset_n),
        .partial_reset_n_in(partial_reset_n),
        .byte_order_select_n_in(byte_order_select_n),
        .flag_timing_select_in(flag_timing_select),
        .parity_placement_select_in(parity_placement_select),
        .fall_through_mode_in(fall_through_mode),
        .wr_en_in(wr_en), .rd_en_in(rd_en),
        .offset_load_in(offset_load_in),
        .offset_sel_full_in(offset_sel_full_in),
        .offset_data_in(offset_data_in), .long_word_in(long_word_in),
        .half_sel_in(half_sel_in), .half_word_out(half_word),
        .full_flag_n_out(full_n), .empty_flag_n_out(empty_n),
        .almost_full_flag_n_out(af_n), .almost_empty_flag_n_out(ae_n),
        .cfg_out(cfg), .empty_offset_out(n_off), .full_offset_out(m_off));

    // Counted comparison of a wide value; a mismatch is reported at once.
    task automatic chk_val(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk_val

    // Counted comparison of a single flag.
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({35'h0, got}, {35'h0, exp});
    endtask : chk_bit

    // Small helpers; requests end one edge before returning.
    task automatic step(input int n);
        repeat (n) @(negedge clk_in);
    endtask : step
    task automatic wr(input int n);
        fsf_peer_inst.burst(1'b0, n);
        step(1);
    endtask : wr
    task automatic rd(input int n);
        fsf_peer_inst.burst(1'b1, n);
        step(1);
    endtask : rd
    task automatic load(input logic full, input logic [35:0] d);
        @(negedge clk_in);
        offset_load_in = 1'b1;
        offset_sel_full_in = full;
        offset_data_in = d;
        @(negedge clk_in);
        offset_load_in = 1'b0;
    endtask : load

    // All sixteen option sets are captured and then held.
    task automatic t_cfg();
        fsf_pkg::fsf_cfg_s c;
        for (int i = 0; i < 16; i++) begin
            c = fsf_pkg::fsf_cfg_s'(4'(i));
            fsf_peer_inst.master_reset_pulse(c);
            chk_val(36'(cfg), 36'(c));
        end
        $display("test cfg done");
    endtask : t_cfg

    // Half order of a long word for both byte orders.
    task automatic t_bus();
        fsf_pkg::fsf_cfg_s c;
        logic [35:0] e;
        for (int le = 0; le < 2; le++) begin
            c = fsf_pkg::FSF_CFG_RST;
            c.little_endian = 1'(le);
            fsf_peer_inst.master_reset_pulse(c);
            for (int s = 0; s < 2; s++) begin
                half_sel_in = 1'(s);
                step(1);
                e = ((s ^ le) == 1) ? 36'(long_word_in[17:0]) :
                    36'(long_word_in[35:18]);
                chk_val(36'(half_word), e);
            end
        end
        $display("test bus done");
    endtask : t_bus

    // Bit 8 set tells the two parity placements apart; the top nibble set is ignored by both.
    task automatic t_parity();
        fsf_pkg::fsf_cfg_s c;
        for (int par = 0; par < 2; par++) begin
            c = fsf_pkg::FSF_CFG_RST;
            c.interspersed = 1'(par);
            fsf_peer_inst.master_reset_pulse(c);
            load(1'b1, 36'hF00000155);
            chk_val(36'(m_off), (par == 1) ? 36'h55 : 36'h155);
        end
        $display("test parity done");
    endtask : t_parity

    // Standard mode, synchronous almost flags, n = 2 and m = 16'hFFF0.
    task automatic t_std();
        fsf_pkg::fsf_cfg_s c;
        c = fsf_pkg::FSF_CFG_RST;
        c.sync_flags = 1'b1;
        fsf_peer_inst.master_reset_pulse(c);
        load(1'b1, 36'hFFF0);
        load(1'b0, 36'h2);
        chk_val(36'(n_off), 36'h2);
        chk_bit(empty_n, 1'b0);
        wr(1);
        chk_bit(empty_n, 1'b0);
        step(2);
        chk_bit(empty_n, 1'b1);
        wr(1);
        chk_bit(ae_n, 1'b0);
        wr(1);
        chk_bit(ae_n, 1'b1);
        wr(12);
        chk_bit(af_n, 1'b1);
        wr(1);
        chk_bit(af_n, 1'b0);
        rd(1);
        chk_bit(af_n, 1'b1);
        rd(13);
        chk_bit(ae_n, 1'b0);
        fsf_peer_inst.partial_reset_pulse();
        chk_bit(empty_n, 1'b0);
        chk_val(36'(m_off), 36'hFFF0);
        $display("test standard done");
    endtask : t_std

    // Fall-through mode, asynchronous almost flags.
    task automatic t_ft();
        fsf_pkg::fsf_cfg_s c;
        c = fsf_pkg::FSF_CFG_RST;
        c.mode = fsf_pkg::FSF_FALL_THROUGH_MODE;
        fsf_peer_inst.master_reset_pulse(c);
        load(1'b1, 36'hFFF0);
        load(1'b0, 36'h2);
        chk_bit(full_n, 1'b0);
        chk_bit(empty_n, 1'b1);
        wr(1);
        chk_bit(empty_n, 1'b1);
        step(4);
        chk_bit(empty_n, 1'b0);
        step(8);
        chk_bit(empty_n, 1'b0);
        rd(1);
        step(4);
        chk_bit(empty_n, 1'b1);
        wr(3);
        chk_bit(ae_n, 1'b0);
        wr(1);
        chk_bit(ae_n, 1'b1);
        wr(12);
        chk_bit(af_n, 1'b1);
        wr(1);
        chk_bit(af_n, 1'b0);
        rd(1);
        chk_bit(af_n, 1'b1);
        $display("test fall through done");
    endtask : t_ft

    // Fill to the depth, try one refused write, then free one place.
    task automatic t_full();
        fsf_peer_inst.master_reset_pulse(fsf_pkg::FSF_CFG_RST);
        wr(65535);
        step(2);
        chk_bit(full_n, 1'b1);
        wr(1);
        chk_bit(full_n, 1'b1);
        step(2);
        chk_bit(full_n, 1'b0);
        wr(1);
        rd(1);
        step(2);
        chk_bit(full_n, 1'b1);
        wr(1);
        step(2);
        chk_bit(full_n, 1'b0);
        $display("test full done");
    endtask : t_full

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence; the long fill runs last.
    initial begin
        step(2);
        rst_n_in = 1'b1;
        step(3);
        t_cfg();
        t_bus();
        t_parity();
        t_std();
        t_ft();
        t_full();
        report_and_stop();
    end

    // The tests need about 66k cycles; 80k means something hung.
    initial begin
        #800000;
        fails++;
        $display("watchdog expired at %0t", $time);
        report_and_stop();
    end
endmodule : fsf_status_flags_tb
